//--- core/adc_conv_ctrl.sv
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// control and status of the successive-approximation converter
module adc_conv_ctrl
   import adc_ctrl_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES
) (
   input  wire logic                       ref_clk_i,
   input  wire logic                       reset_i,
   input  wire logic [adc_ctrl_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [adc_ctrl_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                       write_i,
   input  wire logic                       read_i,
   output logic [adc_ctrl_pkg::DATA_W-1:0] rdata_o,
   input  wire logic                       hardware_trigger_input_i,
   input  wire logic                       core_done_i,
   input  wire logic [adc_ctrl_pkg::RES_W-1:0] core_result_i,
   output logic                            core_start_o,
   output logic                            core_abort_o,
   output logic                            core_power_o,
   output logic [4:0]                      core_channel_o,
   output logic                            core_wide_o,
   output logic                            done_irq_o
);
   import adc_ctrl_pkg::*;

   logic [4:0]        channel_select_q;
   logic              continuous_enable_q;
   logic              done_interrupt_enable_q;
   logic              conversion_done_flag_q;
   logic              conversion_active_flag_q;
   logic              trigger_select_q;
   logic              compare_enable_q;
   logic              compare_direction_q;
   logic [7:0]        compare_value_low_q;
   logic [1:0]        compare_value_high_q;
   logic [7:0]        config_q;
   logic [7:0]        result_lower_byte_q;
   logic [1:0]        result_upper_bits_q;
   logic              interlock_q;
   logic              done_irq_q;
   logic [7:0]        rdata_q;
   logic [15:0]       conv_cnt_q;
   conv_state_e       state_q;
   conv_state_e       state_d;

   logic              wr_one;
   logic              wr_two;
   logic              wr_cfg;
   logic              rd_lower;
   logic              rd_upper;
   logic              hw_pulse;
   logic              trigger;
   logic              conv_end;
   logic              cmp_hit;
   logic              qualify;
   logic              wide;
   logic [RES_W-1:0]  result_now;

   assign wr_one   = write_i && (addr_i == ADDR_CTRL_ONE);
   assign wr_two   = write_i && (addr_i == ADDR_CTRL_TWO);
   assign wr_cfg   = write_i && (addr_i == ADDR_CONFIG);
   assign rd_lower = read_i && (addr_i == ADDR_RES_LOWER);
   assign rd_upper = read_i && (addr_i == ADDR_RES_UPPER);
   assign wide     = mode_is_10bit(config_q[CFG_MODE_LSB +: 2]); // see R22

   // edge detector: a held trigger starts one conversion only
   trigger_edge u_trigger_edge (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .level_i   (hardware_trigger_input_i),
      .pulse_o   (hw_pulse)
   );

   // a write to control one with a channel other than all ones triggers in software mode; a periodic
   // counter overflow is the trigger in hardware mode
   assign trigger = trigger_select_q ? hw_pulse : 1'b0; // see R12 see R21

   // the internal counter stands in for the analog core when it has no done
   assign conv_end = (state_q == ST_CONV) &&
                     (core_done_i || (conv_cnt_q == 16'(CONV_LEN - 1)));

   assign result_now = core_result_i;

   result_compare #(
      .RES_WIDTH (RES_W)
   ) u_result_compare (
      .result_i     (result_now),
      .cmp_low_i    (compare_value_low_q),
      .cmp_high_i   (compare_value_high_q),
      .wide_i       (wide),
      .greater_eq_i (compare_direction_q),
      .hit_o        (cmp_hit)
   );

   // qualifying completion: compare off, or compare on and condition true
   assign qualify = conv_end && (!compare_enable_q || cmp_hit); // see R2 see R3 see R14

   // conversion sequencer; a control-one write aborts and may restart
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (channel_select_q != CHAN_OFF && trigger) begin // see R6
               state_d = ST_START;
            end
         end
         ST_START: begin
            state_d = ST_CONV;
         end
         ST_CONV: begin
            if (conv_end) begin
               // back to back repeats only in continuous mode
               state_d = continuous_enable_q ? ST_START : ST_IDLE; // see R7 see R10
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (wr_one) begin // see R1
         if (wdata_i[4:0] == CHAN_OFF) begin
            state_d = ST_IDLE; // see R9
         end else if (!trigger_select_q) begin
            state_d = ST_START;
         end else begin
            state_d = ST_IDLE; // hardware mode waits for the next overflow
         end
      end
   end

   // state register
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // conversion length counter, restarted at every start
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         conv_cnt_q <= '0;
      end else if (state_q != ST_CONV) begin
         conv_cnt_q <= '0;
      end else begin
         conv_cnt_q <= conv_cnt_q + 16'h0001;
      end
   end

   // active flag follows the sequencer; an abort that does not restart clears it
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         conversion_active_flag_q <= 1'b0;
      end else begin
         conversion_active_flag_q <= (state_d != ST_IDLE); // see R11
      end
   end

   // control one fields; reserved channel code is stored as written
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         channel_select_q        <= CTRL_ONE_RESET;
         continuous_enable_q     <= 1'b0;
         done_interrupt_enable_q <= 1'b0;
      end else if (wr_one) begin
         channel_select_q        <= wdata_i[4:0]; // see R8
         continuous_enable_q     <= wdata_i[BIT_CONT];
         done_interrupt_enable_q <= wdata_i[BIT_IRQ_EN];
      end
   end

   // control two; active flag and reserved bits ignore writes
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         trigger_select_q    <= 1'b0;
         compare_enable_q    <= 1'b0;
         compare_direction_q <= 1'b0;
      end else if (wr_two) begin
         trigger_select_q    <= wdata_i[BIT_TRIG_SEL];
         compare_enable_q    <= wdata_i[BIT_CMP_EN];
         compare_direction_q <= wdata_i[BIT_CMP_DIR]; // see R25 see R13
      end
   end

   // compare value and configuration registers
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         compare_value_low_q  <= ZERO_BYTE;
         compare_value_high_q <= 2'b00;
         config_q             <= CFG_RESET;
      end else begin
         if (write_i && addr_i == ADDR_CMP_LOW) begin
            compare_value_low_q <= wdata_i;
         end
         if (write_i && addr_i == ADDR_CMP_HIGH) begin
            compare_value_high_q <= wdata_i[1:0];
         end
         if (wr_cfg) begin
            config_q <= wdata_i;
         end
      end
   end

   // done flag: a completion in the same cycle as a clear wins
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         conversion_done_flag_q <= 1'b0;
      end else if (qualify) begin
         conversion_done_flag_q <= 1'b1; // see R2 see R3
      end else if (wr_one || rd_lower) begin
         conversion_done_flag_q <= 1'b0; // see R4
      end
   end

   // interrupt on every setting of the done flag while enabled
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         done_irq_q <= 1'b0;
      end else begin
         done_irq_q <= qualify && done_interrupt_enable_q; // see R5
      end
   end

   // interlock: an upper read in 10-bit mode freezes both results
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         interlock_q <= 1'b0;
      end else if (rd_lower || !wide) begin
         interlock_q <= 1'b0; // see R19
      end else if (rd_upper) begin
         interlock_q <= 1'b1; // see R18
      end
   end

   // result registers; a mode change clears the upper bits as invalid
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         result_lower_byte_q <= ZERO_BYTE;
         result_upper_bits_q <= 2'b00;
      end else if (qualify && !interlock_q) begin // see R17 see R18
         result_lower_byte_q <= result_now[7:0];
         result_upper_bits_q <= wide ? result_now[RES_W-1:8] : 2'b00; // see R16
      end else if (wr_cfg && wdata_i[CFG_MODE_LSB +: 2] != config_q[CFG_MODE_LSB +: 2]) begin
         result_upper_bits_q <= 2'b00; // see R20
      end
   end

   // read mux; reads of control registers have no side effects
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_q <= ZERO_BYTE;
      end else if (read_i) begin
         case (addr_i)
            ADDR_CTRL_ONE: rdata_q <= {conversion_done_flag_q, done_interrupt_enable_q,
                                       continuous_enable_q, channel_select_q}; // see R25
            ADDR_CTRL_TWO: rdata_q <= {conversion_active_flag_q, trigger_select_q,
                                       compare_enable_q, compare_direction_q, 4'h0};
            ADDR_RES_UPPER: rdata_q <= {6'h00, result_upper_bits_q};
            ADDR_RES_LOWER: rdata_q <= result_lower_byte_q;
            ADDR_CMP_HIGH:  rdata_q <= {6'h00, compare_value_high_q};
            ADDR_CMP_LOW:   rdata_q <= compare_value_low_q;
            ADDR_CONFIG:    rdata_q <= config_q;
            default:        rdata_q <= ZERO_BYTE;
         endcase
      end else begin
         rdata_q <= ZERO_BYTE;
      end
   end

   assign rdata_o        = rdata_q;
   assign done_irq_o     = done_irq_q;
   assign core_start_o   = (state_q == ST_START);
   assign core_abort_o   = wr_one && (state_q != ST_IDLE); // see R1
   assign core_power_o   = (state_q != ST_IDLE) && (channel_select_q != CHAN_OFF); // see R9 see R10
   assign core_channel_o = channel_select_q;
   assign core_wide_o    = wide;
endmodule : adc_conv_ctrl

//--- core/adc_ctrl_pkg.sv
// Notes on behaviour
// R1: any write to control one aborts, then restarts unless channel is all ones; the code restarts only in software mode, hardware mode waits for a trigger
// R2: compare off: done flag bit 7 sets at every conversion end
// R3: compare on: done flag sets only when compare condition is true
// R4: done flag clears on control one write or lower result read
// R5: interrupt asserts when done flag sets with enable bit 6 high
// R6: continuous off: one conversion per software write or hardware trigger
// R7: continuous on: conversions repeat back to back after first trigger
// R8: five-bit channel field: 0..27 inputs, 28 reserved, 29 high ref, 30 low ref
// R9: channel all ones disables converter, no extra conversion afterwards
// R10: single mode returns converter to low power after each conversion
// R11: active flag bit 7 of control two set at start, cleared at end or abort
// R12: trigger select bit 6: zero software write, one hardware trigger
// R13: software writes zero to control two bits 1 and 0
// R14: control two bit 5 enables automatic compare
// R15: direction bit 4: zero less than, one greater or equal
// R16: upper result holds bits 9:8, zero in 8-bit mode
// R17: upper result loads at every completion unless compare fails
// R18: 10-bit mode: upper read blocks transfers until lower read
// R19: 8-bit mode: no interlock, every qualifying result transfers
// R20: after resolution change upper result is invalid until next completion
// R21: hardware trigger comes from periodic wakeup counter overflow
// R22: resolution 00 is 8-bit, 10 is 10-bit, 01 and 11 reserved
// R23: compare low byte always, upper two bits only in 10-bit mode
// R24: hardware trigger is edge detected, one conversion per assertion
// R25: control register reads have no side effects, flags ignore writes
package adc_ctrl_pkg;
   localparam int          ADDR_W          = 3;
   localparam int          DATA_W          = 8;
   localparam int          RES_W           = 10;
   localparam logic [2:0]  ADDR_CTRL_ONE   = 3'h0;
   localparam logic [2:0]  ADDR_CTRL_TWO   = 3'h1;
   localparam logic [2:0]  ADDR_RES_UPPER  = 3'h2;
   localparam logic [2:0]  ADDR_RES_LOWER  = 3'h3;
   localparam logic [2:0]  ADDR_CMP_HIGH   = 3'h4;
   localparam logic [2:0]  ADDR_CMP_LOW    = 3'h5;
   localparam logic [2:0]  ADDR_CONFIG     = 3'h6;
   localparam int          BIT_DONE        = 7;
   localparam int          BIT_IRQ_EN      = 6;
   localparam int          BIT_CONT        = 5;
   localparam int          BIT_ACTIVE      = 7;
   localparam int          BIT_TRIG_SEL    = 6;
   localparam int          BIT_CMP_EN      = 5;
   localparam int          BIT_CMP_DIR     = 4;
   localparam int          CFG_MODE_LSB    = 2;
   localparam logic [4:0]  CHAN_OFF        = 5'h1F;
   localparam logic [4:0]  CHAN_LAST_INPUT = 5'h1B;
   localparam logic [4:0]  CHAN_RESERVED   = 5'h1C;
   localparam logic [4:0]  CHAN_HIGH_REF   = 5'h1D;
   localparam logic [4:0]  CHAN_LOW_REF    = 5'h1E;
   localparam logic [1:0]  MODE_8BIT       = 2'h0;
   localparam logic [1:0]  MODE_10BIT      = 2'h2;
   localparam logic [4:0]  CTRL_ONE_RESET  = 5'h1F;
   localparam logic [7:0]  CTRL_TWO_WMASK  = 8'h70;
   localparam logic [7:0]  CFG_RESET       = 8'h00;
   localparam logic [7:0]  ZERO_BYTE       = 8'h00;
   localparam int          CONV_CYCLES     = 24;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_CONV  = 2'b11
   } conv_state_e;

   // true only for the 10-bit code; reserved codes run as 8-bit
   function automatic logic mode_is_10bit(input logic [1:0] mode);
      return mode == MODE_10BIT;
   endfunction : mode_is_10bit
endpackage : adc_ctrl_pkg

//--- core/result_compare.sv
`timescale 1ns/1ps
// compare condition of a fresh result against the programmed value
module result_compare
   import adc_ctrl_pkg::*;
#(
   parameter int RES_WIDTH = 10
) (
   input  wire logic [RES_WIDTH-1:0] result_i,
   input  wire logic [7:0]           cmp_low_i,
   input  wire logic [1:0]           cmp_high_i,
   input  wire logic                 wide_i,
   input  wire logic                 greater_eq_i,
   output logic                      hit_o
);
   logic [RES_WIDTH-1:0] lhs;
   logic [RES_WIDTH-1:0] rhs;

   // upper bits take part only in 10-bit mode
   always_comb begin
      lhs = {{(RES_WIDTH-8){1'b0}}, result_i[7:0]};
      rhs = {{(RES_WIDTH-8){1'b0}}, cmp_low_i};
      if (wide_i) begin // see R23
         lhs = result_i;
         rhs = {cmp_high_i, cmp_low_i};
      end
   end

   assign hit_o = greater_eq_i ? (lhs >= rhs) : (lhs < rhs); // see R15
endmodule : result_compare

//--- core/trigger_edge.sv
`timescale 1ns/1ps
// turns a level trigger into a one-cycle pulse on its rising edge
module trigger_edge (
   input  wire logic ref_clk_i,
   input  wire logic reset_i,
   input  wire logic level_i,
   output logic      pulse_o
);
   logic level_q;

   // previous level; reset high-safe at zero so a stuck-high input fires once
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         level_q <= 1'b0;
      end else begin
         level_q <= level_i;
      end
   end

   assign pulse_o = level_i & ~level_q; // see R24
endmodule : trigger_edge

//--- tb/adc_conv_ctrl_assertions.sv
`timescale 1ns/1ps
// port-level checks of the conversion control block
module adc_conv_ctrl_checker
   import adc_ctrl_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              reset_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              write_i,
   input  wire logic              read_i,
   input  wire logic [DATA_W-1:0] rdata_o,
   input  wire logic              hardware_trigger_input_i,
   input  wire logic              core_done_i,
   input  wire logic [RES_W-1:0]  core_result_i,
   input  wire logic              core_start_o,
   input  wire logic              core_abort_o,
   input  wire logic              core_power_o,
   input  wire logic [4:0]        core_channel_o,
   input  wire logic              core_wide_o,
   input  wire logic              done_irq_o
);
   logic trig_q;
   logic ien_q;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);

   // shadow of trigger select, the start source is not visible at the ports
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) trig_q <= 1'b0;
      else if (write_i && addr_i == ADDR_CTRL_TWO) trig_q <= wdata_i[BIT_TRIG_SEL];
   end

   // shadow of the interrupt enable
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) ien_q <= 1'b0;
      else if (write_i && addr_i == ADDR_CTRL_ONE) ien_q <= wdata_i[BIT_IRQ_EN];
   end

   sw_write_start_a: assert property (write_i && addr_i == ADDR_CTRL_ONE && !trig_q
      && wdata_i[4:0] != CHAN_OFF |=> core_start_o) else $error("no start after write");
   off_write_quiet_a: assert property (write_i && addr_i == ADDR_CTRL_ONE
      && wdata_i[4:0] == CHAN_OFF |=> !core_start_o && !core_power_o) else $error("off ran");
   busy_write_abort_a: assert property (write_i && addr_i == ADDR_CTRL_ONE && core_power_o
      |-> core_abort_o) else $error("no abort on busy write");
   channel_update_a: assert property (write_i && addr_i == ADDR_CTRL_ONE
      |=> core_channel_o == $past(wdata_i[4:0])) else $error("channel not taken");
   mode_update_a: assert property (write_i && addr_i == ADDR_CONFIG
      |=> core_wide_o == ($past(wdata_i[3:2]) == MODE_10BIT)) else $error("mode not taken");
   rdata_idle_a: assert property (!read_i |=> rdata_o == ZERO_BYTE)
      else $error("read data outside read slot");
   unmapped_read_a: assert property (read_i && addr_i == 3'h7 |=> rdata_o == ZERO_BYTE)
      else $error("unmapped read not zero");
   irq_pulse_a: assert property (done_irq_o |=> !done_irq_o)
      else $error("interrupt longer than a pulse");
   irq_enable_a: assert property (done_irq_o |-> ien_q || $past(ien_q))
      else $error("interrupt while disabled");
   off_no_power_a: assert property (core_channel_o == CHAN_OFF |-> !core_power_o)
      else $error("powered while off");
   hw_trig_start_a: assert property ($rose(hardware_trigger_input_i) && trig_q && !write_i
      && !core_power_o && core_channel_o != CHAN_OFF |-> ##[1:3] core_start_o)
      else $error("hardware edge without start");
endmodule : adc_conv_ctrl_checker

//--- tb/adc_conversion_control_status_tb_top.sv
`timescale 1ns/1ps
// register-level bench of the conversion control block against a core model
module adc_conversion_control_status_tb_top;
   import adc_ctrl_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, hw = 1'b0;
   logic [2:0] addr = 3'h0, delay = 3'h2;
   logic [7:0] wdata = 8'h00, rdata;
   logic [9:0] value = 10'h000, result;
   logic done, start, abort, power, wide, irq;
   logic [4:0] chan;
   int n_errors = 0, num_checks = 0;
   bit s;

   adc_conv_ctrl #(.CONV_LEN(8)) uut (.ref_clk_i(clk), .reset_i(rst), .addr_i(addr),
      .wdata_i(wdata), .write_i(wr_s), .read_i(rd_s), .rdata_o(rdata),
      .hardware_trigger_input_i(hw), .core_done_i(done), .core_result_i(result),
      .core_start_o(start), .core_abort_o(abort), .core_power_o(power),
      .core_channel_o(chan), .core_wide_o(wide), .done_irq_o(irq));
   adc_core_model core (.ref_clk_i(clk), .reset_i(rst), .start_i(start), .abort_i(abort),
      .delay_i(delay), .value_i(value), .done_o(done), .result_o(result));

   // free-running bus clock
   initial begin
      forever #10 clk = ~clk;
   end

   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s  <= 1'b0;
      @(posedge clk);
   endtask : wr

   // data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 check(what, rdata, exp);
      @(posedge clk);
   endtask : rd

   task automatic wait_irq(input int lim, output bit seen);
      seen = 1'b0;
      for (int i = 0; i < lim && !seen; i++) begin
         @(posedge clk);
         #1 seen = (irq === 1'b1);
      end
      @(posedge clk); // hand back on an edge so the next request starts there
   endtask : wait_irq

   task automatic conv(input logic [7:0] c, input bit exp, input string what);
      wr(ADDR_CTRL_ONE, c);
      wait_irq(40, s);
      check(what, s, exp);
   endtask : conv

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out

   // watchdog, well beyond the roughly three hundred cycles the tests take
   initial begin
      #100000;
      n_errors++;
      close_out();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(ADDR_CTRL_ONE, 8'h1F, "ctrl one reset");
      rd(ADDR_CTRL_TWO, 8'h00, "ctrl two reset");
      // last input, reserved, both references, then off
      for (int i = 0; i <= int'(CHAN_OFF - CHAN_LAST_INPUT); i++) begin
         wr(ADDR_CTRL_ONE, {3'h0, CHAN_LAST_INPUT + 5'(i)});
         check("channel", chan, CHAN_LAST_INPUT + 5'(i));
      end
      wr(ADDR_CONFIG, 8'h08);
      check("wide", wide, 1'b1);
      $display("test reset_and_channels done");
      value <= 10'h2A5;
      conv(8'h45, 1'b1, "irq single");
      rd(ADDR_CTRL_ONE, 8'hC5, "done set");
      rd(ADDR_CTRL_TWO, 8'h00, "active clear");
      check("power idle", power, 1'b0);
      rd(ADDR_RES_UPPER, 8'h02, "upper");
      rd(ADDR_RES_LOWER, 8'hA5, "lower");
      rd(ADDR_CTRL_ONE, 8'h45, "done cleared");
      $display("test single done");
      value <= 10'h17E;
      conv(8'h45, 1'b1, "irq before lock");
      rd(ADDR_RES_UPPER, 8'h01, "upper locked");
      value <= 10'h3C3;
      wr(ADDR_CTRL_ONE, 8'h05);
      rd(ADDR_CTRL_TWO, 8'h80, "active set");
      repeat (20) @(posedge clk);
      rd(ADDR_RES_LOWER, 8'h7E, "lower held");
      rd(ADDR_RES_UPPER, 8'h01, "upper held");
      $display("test interlock done");
      wr(ADDR_CMP_HIGH, 8'h01);
      wr(ADDR_CMP_LOW, 8'h00);
      wr(ADDR_CTRL_TWO, 8'h20);
      value <= 10'h2A5;
      conv(8'h45, 1'b0, "irq compare false");
      rd(ADDR_CTRL_ONE, 8'h45, "done compare false");
      rd(ADDR_RES_UPPER, 8'h01, "upper kept");
      rd(ADDR_RES_LOWER, 8'h7E, "lower kept");
      wr(ADDR_CTRL_TWO, 8'h30);
      conv(8'h45, 1'b1, "irq compare true");
      rd(ADDR_RES_UPPER, 8'h02, "upper compare");
      rd(ADDR_RES_LOWER, 8'hA5, "lower compare");
      wr(ADDR_CTRL_TWO, 8'h00);
      $display("test compare done");
      wr(ADDR_CONFIG, 8'h00);
      check("narrow", wide, 1'b0);
      rd(ADDR_RES_UPPER, 8'h00, "upper invalid");
      value <= 10'h0C4;
      conv(8'h45, 1'b1, "irq narrow");
      rd(ADDR_RES_UPPER, 8'h00, "upper narrow");
      value <= 10'h033;
      conv(8'h45, 1'b1, "irq narrow again");
      rd(ADDR_RES_LOWER, 8'h33, "lower no lock");
      $display("test narrow done");
      delay <= 3'h6;
      value <= 10'h055;
      conv(8'h65, 1'b1, "irq continuous first");
      wait_irq(40, s);
      check("irq continuous repeat", s, 1'b1);
      wr(ADDR_CTRL_ONE, 8'h1F);
      wait_irq(40, s);
      check("irq after off", s, 1'b0);
      check("power off", power, 1'b0);
      delay <= 3'h2;
      $display("test continuous done");
      wr(ADDR_CTRL_TWO, 8'h40);
      wr(ADDR_CTRL_ONE, 8'h45);
      wait_irq(30, s);
      check("irq no sw start", s, 1'b0);
      hw <= 1'b1;
      wait_irq(30, s);
      check("irq hw trigger", s, 1'b1);
      hw <= 1'b0;
      wr(ADDR_CTRL_TWO, 8'hF0); // reserved low bits kept at zero
      rd(ADDR_CTRL_TWO, 8'h70, "ctrl two mask");
      rd(ADDR_CTRL_TWO, 8'h70, "ctrl two reread");
      rd(3'h7, 8'h00, "unmapped");
      $display("test hardware done");
      close_out();
   end
endmodule : adc_conversion_control_status_tb_top

bind adc_conv_ctrl adc_conv_ctrl_checker chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
   .hardware_trigger_input_i(hardware_trigger_input_i), .core_done_i(core_done_i),
   .core_result_i(core_result_i), .core_start_o(core_start_o), .core_abort_o(core_abort_o),
   .core_power_o(core_power_o), .core_channel_o(core_channel_o), .core_wide_o(core_wide_o),
   .done_irq_o(done_irq_o));

//--- tb/adc_core_model.sv
`timescale 1ns/1ps
// behavioural stand-in for the analog converter core
module adc_core_model (
   input  wire logic       ref_clk_i,
   input  wire logic       reset_i,
   input  wire logic       start_i,
   input  wire logic       abort_i,
   input  wire logic [2:0] delay_i,
   input  wire logic [9:0] value_i,
   output logic            done_o,
   output logic [9:0]      result_o
);
   logic       busy_q;
   logic [2:0] cnt_q;

   // conversion timer: a start restarts it, an abort drops it without a done
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_q <= 1'b0;
         cnt_q  <= 3'h0;
      end else if (start_i) begin
         busy_q <= 1'b1;
         cnt_q  <= 3'h0;
      end else if (abort_i || cnt_q == delay_i) begin
         busy_q <= 1'b0;
      end else if (busy_q) begin
         cnt_q <= cnt_q + 3'h1;
      end
   end

   // done lasts one cycle; outside it the bus shows the inverse so a stale sample shows up
   assign done_o   = busy_q && cnt_q == delay_i;
   assign result_o = done_o ? value_i : ~value_i;
endmodule : adc_core_model
